/* File: common/adcsq_pkg.sv */
// package: register map, field layout and timing constants for the converter sequencer
package adcsq_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DATA_LAST = 8'h1C;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h24;
  localparam int CTL_IEN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_MULTI = 4;
  localparam int CTL_EXT = 3;
  localparam int FLG_ERR = 3;
  localparam int FLG_DONE = 2;
  localparam int RES_W = 10;
  localparam int RES_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7F;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int CONV_TIMEOUT_CLKS = 15;
  localparam int CLK_HZ = 20000000;
  localparam int CONV_CLK_HZ = 1000000;
  localparam int CONV_DIV = CLK_HZ / CONV_CLK_HZ;
  localparam int TRIG_MIN_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_POWER = 5'h02,
    ST_START = 5'h04,
    ST_CONV = 5'h08,
    ST_NEXT = 5'h10
  } adcsq_state_e;

  typedef struct packed {
    logic start;
    logic power_n;
    logic [2:0] chan;
  } adcsq_macro_s;
endpackage : adcsq_pkg

/* File: hdl/adcsq_top.sv */
// converter sequencer: wishbone registers, channel sequencing, done and timeout flags
// Operation
// - setting start, by software or trigger, begins conversion of selected channels
// - with external trigger enabled, timer signal starts a conversion
// - multiple mode converts from channel zero upward to the selected channel
// - each result goes to its own channel's data register and stays there
// - in multiple mode last result is stored after end flag is set
// - when the sequence completes, start returns to zero and block waits
// - reading converted data clears the end flag
// - timer trigger while end flag set sets it again and starts next conversion
// - timeout flag bit 3 set when conversion outlasts 15 conversion clocks
// - on timeout data register keeps old value; late normal finish still stores
// - timeout flag cleared by reset or by writing one to it
// - done flag bit 2 set on normal end with result stored
// - multiple mode sets done at the last channel's end, one cycle before its result is stored
// - done flag works only while interrupt enable bit 6 is one
// - done flag returns to zero when a new conversion starts
// - done cleared by reading data offsets 0x00-0x1C or writing control 0x20
// - results are 10 bits; full scale reads 0xFFC0
// - result sits in bits 15:6, bits 5:0 read zero
// - control: enable 6, start 5, multiple 4, external trigger 3, channel 2:0
// - falling edge of the timer signal is the trigger event
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
module adcsq_top #(
  parameter int CHANNELS = 8,
  parameter int TIMEOUT = adcsq_pkg::CONV_TIMEOUT_CLKS,
  parameter int DIV = adcsq_pkg::CONV_DIV
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [adcsq_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer trigger
  input wire logic timer_trig,
  // analog macro
  output adcsq_pkg::adcsq_macro_s macro_o,
  output logic conv_clk,
  input wire logic macro_eoc,
  input wire logic [adcsq_pkg::RES_W-1:0] macro_result,
  // interrupt request
  output logic conv_end_irq
);
  initial begin
    // timeout and divider counters are five bits wide
    if (CHANNELS != 8 || TIMEOUT < 1 || TIMEOUT > 31 || DIV < 2 || DIV > 32) begin
      $error("adcsq_top: bad parameters");
    end
  end

  adcsq_pkg::adcsq_state_e state_reg;
  logic [7:0] ctrl_reg;
  logic [15:0] data_reg [CHANNELS];
  logic conversion_done_flag;
  logic conversion_timeout_flag;
  logic [2:0] chan_reg;
  logic [4:0] div_reg;
  logic conv_tick;
  logic [4:0] tmo_reg;
  logic trig_s1, trig_s2, trig_s3;
  logic trig_fall;
  logic eoc_s1, eoc_s2;
  logic eoc_q;
  logic [9:0] res_s1, res_s2;
  logic last_pend_reg;
  logic bus_req;
  logic wr_ctrl, wr_flags, rd_data;
  logic sw_start;
  logic go;
  logic seq_last;
  logic store;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = bus_req && wb_we_i && wb_adr_i == adcsq_pkg::OFF_CTRL && wb_sel_i[0];
  assign wr_flags = bus_req && wb_we_i && wb_adr_i == adcsq_pkg::OFF_FLAGS && wb_sel_i[0];
  assign rd_data = bus_req && !wb_we_i && wb_adr_i <= adcsq_pkg::OFF_DATA_LAST
                   && wb_adr_i[1:0] == 2'h0;
  assign sw_start = wr_ctrl && wb_dat_i[adcsq_pkg::CTL_START];
  assign trig_fall = trig_s3 && !trig_s2 && ctrl_reg[adcsq_pkg::CTL_EXT];
  assign go = (sw_start || trig_fall) && state_reg == adcsq_pkg::ST_IDLE;
  // single mode ends on the selected channel; multiple mode walks up to it
  assign seq_last = !ctrl_reg[adcsq_pkg::CTL_MULTI] || chan_reg == ctrl_reg[2:0];
  assign store = state_reg == adcsq_pkg::ST_CONV && eoc_s2;

  // pin-side synchronisers: macro runs off its own analog timing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
      eoc_s1 <= 1'b0;
      eoc_s2 <= 1'b0;
      eoc_q <= 1'b0;
      res_s1 <= '0;
      res_s2 <= '0;
    end else begin
      trig_s1 <= timer_trig;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      eoc_s1 <= macro_eoc;
      eoc_s2 <= eoc_s1;
      eoc_q <= eoc_s2;
      res_s1 <= macro_result;
      res_s2 <= res_s1;
    end
  end

  // conversion clock divider, one-cycle tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
      conv_tick <= 1'b0;
      conv_clk <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (div_reg == 5'(DIV - 1)) begin
        div_reg <= '0;
        conv_tick <= 1'b1;
      end else begin
        div_reg <= div_reg + 5'h01;
      end
      conv_clk <= state_reg == adcsq_pkg::ST_CONV && div_reg < 5'(DIV / 2);
    end
  end

  // sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= adcsq_pkg::ST_IDLE;
      chan_reg <= 3'h0;
      tmo_reg <= '0;
    end else begin
      case (state_reg)
        adcsq_pkg::ST_IDLE: begin
          if (go) begin
            chan_reg <= wb_dat_i[adcsq_pkg::CTL_MULTI] && sw_start ? 3'h0 :
                        ctrl_reg[adcsq_pkg::CTL_MULTI] && !sw_start ? 3'h0 :
                        sw_start ? wb_dat_i[2:0] : ctrl_reg[2:0];
            state_reg <= adcsq_pkg::ST_POWER;
          end
        end
        adcsq_pkg::ST_POWER: state_reg <= adcsq_pkg::ST_START;
        adcsq_pkg::ST_START: begin
          tmo_reg <= '0;
          if (!eoc_s2) state_reg <= adcsq_pkg::ST_CONV;
        end
        adcsq_pkg::ST_CONV: begin
          if (store) begin
            state_reg <= seq_last ? adcsq_pkg::ST_IDLE : adcsq_pkg::ST_NEXT;
          end else if (conv_tick) begin
            if (tmo_reg == 5'(TIMEOUT - 1)) state_reg <= adcsq_pkg::ST_IDLE;
            tmo_reg <= tmo_reg + 5'h01;
          end
        end
        adcsq_pkg::ST_NEXT: begin
          chan_reg <= chan_reg + 3'h1;
          state_reg <= adcsq_pkg::ST_START;
        end
        default: state_reg <= adcsq_pkg::ST_IDLE;
      endcase
    end
  end

  // control register; start self-clears at sequence end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= adcsq_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[7:0] & adcsq_pkg::CTRL_WMASK;
      end
      // clearing start mid-sequence does not stop it, only the sequencer ends it
      if (wr_ctrl && !wb_dat_i[adcsq_pkg::CTL_START] && state_reg != adcsq_pkg::ST_IDLE) begin
        ctrl_reg[adcsq_pkg::CTL_START] <= 1'b1;
      end
      if (trig_fall && state_reg == adcsq_pkg::ST_IDLE) begin
        ctrl_reg[adcsq_pkg::CTL_START] <= 1'b1;
      end
      if (state_reg == adcsq_pkg::ST_CONV && (store ? seq_last :
          conv_tick && tmo_reg == 5'(TIMEOUT - 1))) begin
        ctrl_reg[adcsq_pkg::CTL_START] <= 1'b0;
      end
    end
  end

  // per-channel results; timeout leaves old data, late eoc still stores
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CHANNELS; i++) data_reg[i] <= adcsq_pkg::DATA_RESET;
      last_pend_reg <= 1'b0;
    end else begin
      last_pend_reg <= 1'b0;
      if (store && !(ctrl_reg[adcsq_pkg::CTL_MULTI] && seq_last)) begin
        data_reg[chan_reg] <= {res_s2, 6'h00};
      end
      // last channel of a multiple-mode sequence lands one cycle after done flag rises
      if (store && ctrl_reg[adcsq_pkg::CTL_MULTI] && seq_last) last_pend_reg <= 1'b1;
      if (last_pend_reg) data_reg[ctrl_reg[2:0]] <= {res_s2, 6'h00};
      // late eoc after a timeout: only the synchronised copy is read
      if (state_reg == adcsq_pkg::ST_IDLE && eoc_s2 && !eoc_q && tmo_reg != '0) begin
        data_reg[chan_reg] <= {res_s2, 6'h00};
      end
    end
  end

  // flags and interrupt request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
      conversion_timeout_flag <= 1'b0;
      conv_end_irq <= 1'b0;
    end else begin
      conv_end_irq <= 1'b0;
      if (wr_flags && wb_dat_i[adcsq_pkg::FLG_ERR]) conversion_timeout_flag <= 1'b0;
      if (state_reg == adcsq_pkg::ST_CONV && !store && conv_tick
          && tmo_reg == 5'(TIMEOUT - 1)) begin
        conversion_timeout_flag <= 1'b1;
      end
      // a trigger while done is set restarts; done rises again at that sequence end
      if (rd_data || wr_ctrl || go) conversion_done_flag <= 1'b0;
      if (store && seq_last && ctrl_reg[adcsq_pkg::CTL_IEN]) begin
        conversion_done_flag <= 1'b1;
        conv_end_irq <= 1'b1;
      end
    end
  end

  // macro control outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      macro_o <= '{start: 1'b0, power_n: 1'b1, chan: 3'h0};
    end else begin
      macro_o.power_n <= state_reg == adcsq_pkg::ST_IDLE;
      macro_o.start <= state_reg == adcsq_pkg::ST_START;
      macro_o.chan <= chan_reg;
    end
  end

  // wishbone read and ack, one wait state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        if (rd_data) wb_dat_o <= {16'h0000, data_reg[wb_adr_i[4:2]]};
        else if (wb_adr_i == adcsq_pkg::OFF_CTRL) wb_dat_o <= {24'h000000, ctrl_reg};
        else if (wb_adr_i == adcsq_pkg::OFF_FLAGS) begin
          wb_dat_o[adcsq_pkg::FLG_ERR] <= conversion_timeout_flag;
          wb_dat_o[adcsq_pkg::FLG_DONE] <= conversion_done_flag;
        end
      end
    end
  end
endmodule : adcsq_top

/* File: testbench/adcsq_macro_model.sv */
// model of the analog conversion macro
`timescale 1ns/100ps
module adcsq_macro_model (
  // system
  input wire logic clk,
  // macro
  input wire adcsq_pkg::adcsq_macro_s macro_o,
  input wire logic hang,
  output logic macro_eoc,
  output logic [adcsq_pkg::RES_W-1:0] macro_result
);
  int cnt = 0;
  logic start_q = 1'b0;
  logic [9:0] res = 10'h000;
  always @(posedge clk) begin
    start_q <= macro_o.start;
    if (macro_o.start && !start_q && !hang) begin
      cnt <= 14;
      res <= (macro_o.chan == 3'h7) ? 10'h3FF : {macro_o.chan, 7'h15};
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // eoc held six cycles, then result scrambled so stale data is not read
  assign macro_eoc = (cnt > 0) && (cnt <= 6);
  assign macro_result = macro_eoc ? res : ~res;
endmodule : adcsq_macro_model

/* File: testbench/adcsq_chk.sv */
// checker: bus answer, macro sequencing and flag event assertions
`timescale 1ns/100ps
module adcsq_chk (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // macro and event
  input wire adcsq_pkg::adcsq_macro_s macro_o,
  input wire logic conv_clk,
  input wire logic macro_eoc,
  input wire logic conv_end_irq
);
  logic first_q;
  logic [2:0] last_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b1;
      last_q <= 3'h0;
    end else if (macro_o.power_n) begin
      first_q <= 1'b1;
    end else if (macro_o.start) begin
      first_q <= 1'b0;
      last_q <= macro_o.chan;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_irq_pulse: assert property (conv_end_irq |=> !conv_end_irq)
    else $error("irq longer than one cycle");
  a_irq_eoc: assert property (conv_end_irq |-> $past(macro_eoc, 2))
    else $error("irq without end of conversion");
  a_start_busy: assert property (macro_o.start |-> !macro_o.power_n)
    else $error("start while powered down");
  a_clk_idle: assert property (macro_o.power_n && $past(macro_o.power_n) |-> !conv_clk)
    else $error("conversion clock while idle");
  a_chan_step: assert property ($rose(macro_o.start) && !first_q |-> macro_o.chan == last_q + 3'h1)
    else $error("channel sequence not upward by one");
  a_chan_hold: assert property (macro_o.start && $past(macro_o.start) |-> $stable(macro_o.chan))
    else $error("channel changed during start");
  a_busy_bound: assert property ($fell(macro_o.power_n) |-> ##[1:900] macro_o.power_n)
    else $error("sequence never returned to idle");
  c_irq: cover property (conv_end_irq);
  c_step: cover property ($rose(macro_o.start) && !first_q && macro_o.chan == 3'h7);
  c_trig: cover property ($fell(macro_o.power_n));
endmodule : adcsq_chk
bind adcsq_top adcsq_chk u_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .macro_o,
  .conv_clk, .macro_eoc, .conv_end_irq);

/* File: testbench/tb_top.sv */
// testbench: registers, single, multiple, timeout and trigger runs
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, conv_clk, macro_eoc, conv_end_irq;
  logic timer_trig = 1'b1;
  logic hang = 1'b0;
  logic [9:0] macro_result;
  adcsq_pkg::adcsq_macro_s macro_o;
  int error_cnt = 0;
  int n_tests = 0;
  adcsq_top #(.DIV(2)) dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_trig, .macro_o, .conv_clk,
    .macro_eoc, .macro_result, .conv_end_irq);
  adcsq_macro_model u_mac (.clk, .macro_o, .hang, .macro_eoc, .macro_result);
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000);
    chk(wb_dat_o, e);
  endtask : rd
  task automatic wait_pn(input logic v);
    do @(negedge clk); while (macro_o.power_n !== v);
  endtask : wait_pn
  task automatic run(input logic [7:0] c);
    wb(1'b1, 8'h20, {24'h000000, c});
    do @(negedge clk); while (conv_end_irq !== 1'b1);
    wait_pn(1'b1);
  endtask : run
  function automatic logic [31:0] exp_d(input logic [2:0] ch);
    return (ch == 3'h7) ? 32'h0000FFC0 : {16'h0000, ch, 7'h15, 6'h00};
  endfunction : exp_d
  task automatic t_basic();
    rd(8'h24, 32'h00000000);
    rd(8'h40, 32'h00000000);
    run(8'h61);
    rd(8'h24, 32'h00000004);
    rd(8'h20, 32'h00000041);
    rd(8'h04, exp_d(3'h1));
    rd(8'h24, 32'h00000000);
    run(8'h77);
    rd(8'h24, 32'h00000004);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), exp_d(3'(i)));
    end
    rd(8'h20, 32'h00000057);
    run(8'h61);
    wb(1'b1, 8'h20, 32'h00000040);
    rd(8'h24, 32'h00000000);
  endtask : t_basic
  task automatic t_timeout();
    hang <= 1'b1;
    wb(1'b1, 8'h20, 32'h00000062);
    wait_pn(1'b0);
    wait_pn(1'b1);
    rd(8'h24, 32'h00000008);
    rd(8'h08, exp_d(3'h2));
    wb(1'b1, 8'h24, 32'h00000008);
    rd(8'h24, 32'h00000000);
    hang <= 1'b0;
  endtask : t_timeout
  task automatic t_trig();
    wb(1'b1, 8'h20, 32'h0000004B);
    for (int k = 0; k < 2; k++) begin
      timer_trig <= 1'b0;
      wait_pn(1'b0);
      rd(8'h24, 32'h00000000);
      do @(negedge clk); while (conv_end_irq !== 1'b1);
      wait_pn(1'b1);
      @(posedge clk);
      timer_trig <= 1'b1;
      rd(8'h24, 32'h00000004);
    end
    rd(8'h0C, exp_d(3'h3));
  endtask : t_trig
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_basic();
    t_timeout();
    t_trig();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
